// *** rtl/spm_pkg.sv ***
// Constants shared by the serial port modules.
package spm_pkg;
	// Register indices; the APB byte address is four times the index.
	localparam logic [7:0]  IDX_DATA   = 8'h21;
	localparam logic [7:0]  IDX_CTRL   = 8'h22;
	localparam logic [7:0]  IDX_STAT   = 8'h23;
	localparam int          ADDR_W     = 12;
	// Control field positions.
	localparam int          CB_IRQ_EN  = 7;
	localparam int          CB_PORT_EN = 6;
	localparam int          CB_DIV_DIS = 5;
	localparam int          CB_MASTER  = 4;
	localparam int          CB_IDLE    = 3;
	localparam int          CB_PHASE   = 2;
	// Status field positions.
	localparam int          SB_DONE    = 7;
	localparam int          SB_WRITE_COLLISION_FLAG    = 6;
	localparam int          SB_MODE_FAULT_FLAG    = 4;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  STAT_RST   = 8'h00;
	// Half serial clock periods in pclk cycles.
	localparam logic [6:0]  HALF_2     = 7'h01;
	localparam logic [6:0]  HALF_8     = 7'h04;
	localparam logic [6:0]  HALF_16    = 7'h08;
	localparam logic [6:0]  HALF_32    = 7'h10;
	localparam logic [6:0]  HALF_64    = 7'h20;
	localparam logic [6:0]  HALF_128   = 7'h40;
	localparam logic [4:0]  LAST_EDGE  = 5'h0F;
	localparam logic [3:0]  LAST_BIT   = 4'h7;
	// Pin synchroniser order: sck, mosi, miso, select.
	localparam int          SYNC_N     = 4;
	localparam logic [3:0]  SYNC_RST   = 4'h8;
endpackage

// *** rtl/spm_shift_if.sv ***
// Control and data link between the port core and its shift register.
`timescale 1ns/100ps
`default_nettype none
interface spm_shift_if;
	logic       load;
	logic [7:0] ld_data;
	logic       sample;
	logic       in_bit;
	logic       launch;
	logic [7:0] sr;
	logic       out_bit;
	modport ctl (output load, ld_data, sample, in_bit, launch,
		input sr, out_bit);
	modport sh  (input load, ld_data, sample, in_bit, launch,
		output sr, out_bit);
endinterface
`default_nettype wire

// *** rtl/spm_shift.sv ***
// Eight bit shift register with a separately launched output bit.
`timescale 1ns/100ps
`default_nettype none
module spm_shift (
	input  wire logic pclk,
	input  wire logic presetn,
	spm_shift_if.sh   sif
);
	// The output bit is held apart from the register so that capture and
	// launch can fall on different serial clock edges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sif.sr <= 8'h00;
			sif.out_bit <= 1'b0;
		end else if (sif.load) begin
			sif.sr <= sif.ld_data;
			sif.out_bit <= sif.ld_data[7];
		end else begin
			if (sif.sample)
				sif.sr <= {sif.sr[6:0], sif.in_bit};
			if (sif.launch)
				sif.out_bit <= sif.sr[7];
		end
	end
endmodule
`default_nettype wire

// *** rtl/spm_baud.sv ***
// Serial clock rate divider giving a one-cycle tick per half period.
`timescale 1ns/100ps
`default_nettype none
module spm_baud
	import spm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clr,
	input  wire logic       en,
	input  wire logic       div_dis,
	input  wire logic [1:0] rate,
	output logic            tick
);
	logic [6:0] cnt_reg;
	logic [6:0] half;

	always_comb begin
		case ({div_dis, rate})
		3'b100:  half = HALF_2;
		3'b000:  half = HALF_8;
		3'b001:  half = HALF_16;
		3'b110:  half = HALF_32;
		3'b010:  half = HALF_64;
		3'b011:  half = HALF_128;
		default: half = HALF_2;
		endcase
	end

	assign tick = en && (cnt_reg == half - 7'h01);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_reg <= 7'h00;
		else if (clr || tick)
			cnt_reg <= 7'h00;
		else if (en)
			cnt_reg <= cnt_reg + 7'h01;
	end
endmodule
`default_nettype wire

// *** rtl/spm_core.sv ***
// Serial peripheral port: APB registers, master and slave engines.
//
// Notes on behaviour
// - With done flag set, buffer keeps first byte; later bytes dropped.
// - No flag or interrupt reports a receive overrun.
// - Wait state has no effect; interrupt request stays live.
// - Halt freezes all registers; own events cannot end halt. Here the bus registers, irq and miso_oe still update.
// - One interrupt: enable and (done flag or mode fault flag).
// - Port enable connects pins; reset 0; cleared by mode fault.
// - Master clock divide by 2,8,16,32,64,128 from three rate bits.
// - Rate bits unused in slave mode; clock comes from master.
// - Master select chooses mode, swaps pins; cleared on mode fault.
// - Idle level bit sets clock level between transfers.
// - Phase bit picks first or second edge as first capture.
// - Done flag set at end; cleared by status then data access.
// - Data writes ignored while done flag is set.
// - Data write during transfer sets collision flag, is discarded.
// - Select low in master sets fault; status then control clears.
// - Master transfer starts only on a data register write.
// - Received byte copied to buffer as done sets; reads see it.
// - Data write loads the transmit shift register directly.
// - Slave without new data echoes the previously received byte.
// - Eight clock pulses per byte, most significant bit first.
// - Collision flag never raises the interrupt.
// - During mode fault, setting enable or master needs clearing write.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module spm_core
	import spm_pkg::*;
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [spm_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       sck_i,
	output logic                            sck_o,
	output logic                            sck_oe,
	input  wire logic                       mosi_i,
	output logic                            mosi_o,
	output logic                            mosi_oe,
	input  wire logic                       miso_i,
	output logic                            miso_o,
	output logic                            miso_oe,
	input  wire logic                       ss_n_i,
	input  wire logic                       halt_mode,
	output logic                            irq
);
	import spm_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [SYNC_N-1:0] pin_in;
	logic [SYNC_N-1:0] s1_reg;
	logic [SYNC_N-1:0] s2_reg;
	logic [SYNC_N-1:0] s3_reg;
	logic [SYNC_N-1:0] lvl_reg;
	assign pin_in = {ss_n_i, miso_i, mosi_i, sck_i};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_reg[gi] <= SYNC_RST[gi];
					s2_reg[gi] <= SYNC_RST[gi];
					s3_reg[gi] <= SYNC_RST[gi];
					lvl_reg[gi] <= SYNC_RST[gi];
				end else begin
					s1_reg[gi] <= pin_in[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi])
						lvl_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// State and decode
	logic [7:0] ctrl_reg;
	logic       done_reg;
	logic       write_collision_flag_reg;
	logic       mode_fault_flag_reg;
	logic       arm_done_reg;
	logic       arm_write_collision_flag_reg;
	logic       arm_mode_fault_flag_reg;
	logic [7:0] rx_buf_reg;
	logic       busy_reg;
	logic [4:0] edge_reg;
	logic       sck_reg;
	logic       sck_prev_reg;
	logic [3:0] scnt_reg;
	logic       sact_reg;
	logic [3:0] mcnt_reg;

	spm_shift_if sif ();

	logic run;
	logic acc;
	logic hit_data;
	logic hit_ctrl;
	logic hit_stat;
	logic wr_data;
	logic cr_wr;
	logic is_master;
	logic pen;
	logic clock_idle_level_bit;
	logic clock_phase_bit;
	logic ss_low;
	logic fault;
	logic slv_sel;
	logic sck_edge;
	logic lead;
	logic trail;
	logic slv_busy;
	logic busy_any;
	logic wr_ok;
	logic start;
	logic tick;
	logic m_sample;
	logic m_done;
	logic slv_sample;
	logic s_done;
	logic xfer_done;
	logic [7:0] status;

	// Halt freezes all but the pin synchronisers, forces the interrupt request low and clears miso_oe; the bus still answers but has no effect.
	assign run      = !halt_mode;
	assign acc      = psel && penable && pready && run;
	assign hit_data = acc && (paddr == {2'b00, IDX_DATA, 2'b00});
	assign hit_ctrl = acc && (paddr == {2'b00, IDX_CTRL, 2'b00});
	assign hit_stat = acc && (paddr == {2'b00, IDX_STAT, 2'b00});
	assign wr_data  = hit_data && pwrite;
	assign cr_wr    = hit_ctrl && pwrite;

	assign is_master = ctrl_reg[CB_MASTER];
	assign pen       = ctrl_reg[CB_PORT_EN];
	assign clock_idle_level_bit      = ctrl_reg[CB_IDLE];
	assign clock_phase_bit      = ctrl_reg[CB_PHASE];
	assign ss_low    = !lvl_reg[3];
	assign fault     = run && pen && is_master && ss_low;
	assign slv_sel   = run && pen && !is_master && ss_low;

	// Slave clock comes from the pin; rate bits play no part here.
	assign sck_edge = lvl_reg[0] != sck_prev_reg;
	assign lead     = sck_edge && (lvl_reg[0] != clock_idle_level_bit);
	assign trail    = sck_edge && (lvl_reg[0] == clock_idle_level_bit);
	assign slv_sample = slv_sel && (clock_phase_bit ? trail : lead);
	assign s_done   = slv_sample && (scnt_reg == LAST_BIT);
	// With phase 0 the slave is busy for as long as it is selected, so
	// software must see select high before reloading the data register.
	assign slv_busy = slv_sel && (!clock_phase_bit || sact_reg);

	assign busy_any = busy_reg || slv_busy;
	assign wr_ok    = wr_data && !done_reg && !busy_any;
	assign start    = wr_ok && is_master && pen;
	assign m_sample = tick && (edge_reg[0] == clock_phase_bit);
	assign m_done   = tick && (edge_reg == LAST_EDGE);
	assign xfer_done = m_done || s_done;

	assign status = {done_reg, write_collision_flag_reg, 1'b0, mode_fault_flag_reg, 4'h0};

	spm_baud u_baud (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (start),
		.en      (busy_reg && run),
		.div_dis (ctrl_reg[CB_DIV_DIS]),
		.rate    (ctrl_reg[1:0]),
		.tick    (tick)
	);

	assign sif.load    = wr_ok;
	assign sif.ld_data = pwdata[7:0];
	assign sif.sample  = m_sample || slv_sample;
	assign sif.in_bit  = is_master ? lvl_reg[2] : lvl_reg[1];
	// While idle the output bit tracks the register, so an unreloaded
	// slave presents the byte it last received.
	assign sif.launch  = (tick && !m_sample)
		|| (slv_sel && (clock_phase_bit ? lead : trail))
		|| (run && !busy_any);

	spm_shift u_shift (
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (sif)
	);

	// ==========================================================
	// APB slave with one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			if (psel && penable && !pready) begin
				prdata <= 32'h0000_0000;
				case (paddr)
				{2'b00, IDX_DATA, 2'b00}: prdata[7:0] <= rx_buf_reg;
				{2'b00, IDX_CTRL, 2'b00}: prdata[7:0] <= ctrl_reg;
				{2'b00, IDX_STAT, 2'b00}: prdata[7:0] <= status;
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
		end else if (fault) begin
			ctrl_reg[CB_PORT_EN] <= 1'b0;
			ctrl_reg[CB_MASTER] <= 1'b0;
		end else if (cr_wr) begin
			ctrl_reg <= pwdata[7:0];
			if (mode_fault_flag_reg && !arm_mode_fault_flag_reg) begin
				ctrl_reg[CB_PORT_EN] <= pwdata[CB_PORT_EN] && pen;
				ctrl_reg[CB_MASTER] <= pwdata[CB_MASTER] && is_master;
			end
		end
	end

	// ==========================================================
	// Status flags; a setting event wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= STAT_RST[SB_DONE];
			arm_done_reg <= 1'b0;
		end else if (xfer_done) begin
			done_reg <= 1'b1;
		end else if (arm_done_reg && hit_data) begin
			done_reg <= 1'b0;
			arm_done_reg <= 1'b0;
		end else if (hit_stat && done_reg) begin
			arm_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_collision_flag_reg <= STAT_RST[SB_WRITE_COLLISION_FLAG];
			arm_write_collision_flag_reg <= 1'b0;
		end else if (wr_data && !done_reg && busy_any) begin
			write_collision_flag_reg <= 1'b1;
		end else if (arm_write_collision_flag_reg && hit_data) begin
			write_collision_flag_reg <= 1'b0;
			arm_write_collision_flag_reg <= 1'b0;
		end else if (hit_stat && !pwrite && write_collision_flag_reg) begin
			arm_write_collision_flag_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_fault_flag_reg <= STAT_RST[SB_MODE_FAULT_FLAG];
			arm_mode_fault_flag_reg <= 1'b0;
		end else if (fault) begin
			mode_fault_flag_reg <= 1'b1;
		end else if (arm_mode_fault_flag_reg && cr_wr) begin
			mode_fault_flag_reg <= 1'b0;
			arm_mode_fault_flag_reg <= 1'b0;
		end else if (hit_stat && mode_fault_flag_reg) begin
			arm_mode_fault_flag_reg <= 1'b1;
		end
	end

	// Overruns are not flagged: later bytes simply never reach the buffer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_buf_reg <= 8'h00;
		else if (xfer_done && !done_reg) begin
			// A phase 0 master made its last capture one tick before the
			// final edge, so its register already holds the whole byte.
			if (m_done && !m_sample)
				rx_buf_reg <= sif.sr;
			else
				rx_buf_reg <= {sif.sr[6:0], sif.in_bit};
		end
	end

	// Collision is left out of the request on purpose.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= run && ctrl_reg[CB_IRQ_EN]
				&& (done_reg || mode_fault_flag_reg);
	end

	// ==========================================================
	// Master engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			edge_reg <= 5'h00;
			sck_reg <= 1'b0;
			mcnt_reg <= 4'h0;
		end else if (run) begin
			if (fault || m_done || !is_master) begin
				busy_reg <= 1'b0;
				sck_reg <= clock_idle_level_bit;
			end else if (start) begin
				busy_reg <= 1'b1;
				edge_reg <= 5'h00;
				mcnt_reg <= 4'h0;
				sck_reg <= clock_idle_level_bit;
			end else if (tick) begin
				edge_reg <= edge_reg + 5'h01;
				sck_reg <= !sck_reg;
				if (m_sample)
					mcnt_reg <= mcnt_reg + 4'h1;
			end else if (!busy_reg) begin
				sck_reg <= clock_idle_level_bit;
			end
		end
	end

	// ==========================================================
	// Slave engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_prev_reg <= SYNC_RST[0];
			scnt_reg <= 4'h0;
			sact_reg <= 1'b0;
		end else if (run) begin
			sck_prev_reg <= lvl_reg[0];
			if (!slv_sel) begin
				scnt_reg <= 4'h0;
				sact_reg <= 1'b0;
			end else begin
				if (lead)
					sact_reg <= 1'b1;
				if (s_done) begin
					scnt_reg <= 4'h0;
					sact_reg <= 1'b0;
				end else if (slv_sample) begin
					scnt_reg <= scnt_reg + 4'h1;
				end
			end
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_o <= 1'b0;
			mosi_o <= 1'b0;
			miso_o <= 1'b0;
			sck_oe <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			sck_o <= sck_reg;
			mosi_o <= sif.out_bit;
			miso_o <= sif.out_bit;
			sck_oe <= pen && is_master;
			mosi_oe <= pen && is_master;
			miso_oe <= slv_sel;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_arm_done;
		done_reg && hit_stat;
	endsequence
	sequence s_arm_mode_fault_flag;
		mode_fault_flag_reg && hit_stat;
	endsequence

	a_done_clear: assert property (s_arm_done ##[2:8]
		(hit_data && !xfer_done) |=> !done_reg)
		else $error("done flag not cleared by status then data access");
	a_mode_fault_flag_clear: assert property (s_arm_mode_fault_flag ##[2:8]
		(cr_wr && !fault) |=> !mode_fault_flag_reg)
		else $error("mode fault not cleared by status then control write");
	a_fault_drop: assert property (fault |=>
		!ctrl_reg[CB_MASTER] && !ctrl_reg[CB_PORT_EN] && mode_fault_flag_reg)
		else $error("mode fault did not drop master and enable");
	a_wr_ignored: assert property (done_reg && wr_data && !busy_any
		|=> !busy_reg && (done_reg != $past(arm_done_reg)))
		else $error("data write taken while done flag set");
	a_write_collision_flag_set: assert property (wr_data && !done_reg && busy_any
		|=> write_collision_flag_reg && (busy_any || done_reg))
		else $error("collision not flagged");
	a_irq_follow: assert property (run && ctrl_reg[CB_IRQ_EN]
		&& (done_reg || mode_fault_flag_reg) |=> irq)
		else $error("interrupt request missing");
	a_eight_bits: assert property (m_done
		|-> mcnt_reg + {3'h0, m_sample} == LAST_BIT + 4'h1)
		else $error("master byte did not hold eight captures");
	a_halt_frozen: assert property (halt_mode |=>
		$stable(ctrl_reg) && $stable(status) && $stable(rx_buf_reg))
		else $error("registers changed in halt");
	a_rx_keep: assert property (done_reg && !xfer_done |=>
		$stable(rx_buf_reg))
		else $error("receive buffer overwritten while done flag set");
	a_idle_sck: assert property (!busy_reg ##1 !busy_reg
		&& $stable(ctrl_reg) && run |=> sck_reg == $past(clock_idle_level_bit))
		else $error("serial clock not at idle level");
endmodule
`default_nettype wire

// *** verification/spm_peer.sv ***
// Far-side serial peer that answers as a slave or runs transfers as master.
`timescale 1ns/100ps
`default_nettype none
module spm_peer (
	input  wire logic pclk,
	input  wire logic clock_idle_level_bit,
	input  wire logic clock_phase_bit,
	input  wire logic as_master,
	input  wire logic sck_in,
	input  wire logic mosi_in,
	input  wire logic miso_in,
	output logic      sck_out,
	output logic      mosi_out,
	output logic      miso_out,
	output logic      ss_n_out
);
	logic [7:0] tx;
	logic [7:0] rx;
	int         k;
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		miso_out = 1'b0;
		ss_n_out = 1'b1;
		tx = 8'h00;
		rx = 8'h00;
		k = 8;
	end
	// ==========================================================
	// Slave side
	// Past the eighth bit the line is inverted so stale data never matches.
	always @(sck_in) begin
		if (!as_master && k < 8) begin
			if ((sck_in != clock_idle_level_bit) != clock_phase_bit) begin
				rx = {rx[6:0], mosi_in};
				k = k + 1;
			end else begin
				miso_out = tx[7-k];
			end
		end else if (!as_master) begin
			miso_out = ~miso_out;
		end
	end
	task automatic arm(input logic [7:0] b);
		tx = b;
		k = 0;
		miso_out <= b[7];
	endtask
	// ==========================================================
	// Master side
	task automatic xfer(input logic [7:0] b, input int h);
		ss_n_out <= 1'b0;
		repeat (2*h) @(posedge pclk);
		for (int i = 7; i >= 0; i--) begin
			if (!clock_phase_bit) mosi_out <= b[i];
			repeat (h) @(posedge pclk);
			if (!clock_phase_bit) rx = {rx[6:0], miso_in};
			sck_out <= ~clock_idle_level_bit;
			if (clock_phase_bit) mosi_out <= b[i];
			repeat (h) @(posedge pclk);
			if (clock_phase_bit) rx = {rx[6:0], miso_in};
			sck_out <= clock_idle_level_bit;
		end
		repeat (h) @(posedge pclk);
		ss_n_out <= 1'b1;
		mosi_out <= ~mosi_out;
		repeat (2*h) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// *** verification/spi_master_slave_port_bench.sv ***
// Self-checking bench for the serial port core.
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_port_bench import spm_pkg::*;;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        irq;
	logic        halt;
	logic        ss_b;
	logic        clock_idle_level_bit_b, clock_phase_bit_b, as_m;
	logic        p_sck, p_mosi, p_miso, p_ss_n;
	logic        sck_w, mosi_w, miso_w;
	logic        last_err;
	int          fails;
	int          total_checks;
	assign sck_w  = sck_oe ? sck_o : p_sck;
	assign mosi_w = mosi_oe ? mosi_o : p_mosi;
	assign miso_w = miso_oe ? miso_o : p_miso;
	spm_core dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
		.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
		.miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(p_ss_n & ss_b),
		.halt_mode(halt), .irq(irq));
	spm_peer peer_u (.pclk(pclk), .clock_idle_level_bit(clock_idle_level_bit_b), .clock_phase_bit(clock_phase_bit_b),
		.as_master(as_m), .sck_in(sck_w), .mosi_in(mosi_w),
		.miso_in(miso_w), .sck_out(p_sck), .mosi_out(p_mosi),
		.miso_out(p_miso), .ss_n_out(p_ss_n));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge pclk);
		paddr   <= {2'b00, idx, 2'b00};
		pwrite  <= w;
		pwdata  <= {24'h000000, wd};
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) fails++;
		rd = prdata[7:0];
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] v;
		apb(1'b1, idx, d, v);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx,
		input logic [7:0] e);
		logic [7:0] v;
		apb(1'b0, idx, 8'h00, v);
		chk(nm, e, v);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] v;
		rdc("control", IDX_CTRL, CTRL_RST);
		rdc("status", IDX_STAT, STAT_RST);
		apb(1'b0, 8'h30, 8'h00, v);
		chk("slave error", 8'h01, {7'h00, last_err});
		$display("test reset finished");
	endtask
	task automatic t_rates();
		logic [6:0] hexp [8];
		int         n;
		hexp = '{HALF_8, HALF_16, HALF_64, HALF_128,
			HALF_2, HALF_2, HALF_32, HALF_2};
		for (int c = 0; c < 8; c++) begin
			wr(IDX_CTRL, {2'b01, c[2], 3'b100, c[1:0]});
			peer_u.arm(8'h00);
			wr(IDX_DATA, 8'h5A);
			n = 0;
			while (sck_o === 1'b0 && n < 300) begin
				n++;
				@(posedge pclk);
			end
			n = 0;
			while (sck_o === 1'b1 && n < 300) begin
				n++;
				@(posedge pclk);
			end
			chk("half period", {1'b0, hexp[c]}, n[7:0]);
			repeat (16 * hexp[c] + 20) @(posedge pclk);
			rdc("status", IDX_STAT, 8'h80);
			rdc("data", IDX_DATA, 8'h00);
		end
		$display("test rates finished");
	endtask
	task automatic t_master(input logic pl, input logic ph,
		input logic coll, input logic [7:0] d, input logic [7:0] pd);
		int n;
		clock_idle_level_bit_b <= pl;
		clock_phase_bit_b <= ph;
		wr(IDX_CTRL, {4'hD, pl, ph, 2'b01});
		repeat (3) @(posedge pclk);
		chk("idle clock", {7'h00, pl}, {7'h00, sck_o});
		peer_u.arm(pd);
		wr(IDX_DATA, d);
		if (coll) begin
			repeat (20) @(posedge pclk);
			wr(IDX_DATA, 8'hFF);
			chk("collision irq", 8'h00, {7'h00, irq});
		end
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			n++;
			@(posedge pclk);
		end
		chk("done irq", 8'h01, {7'h00, irq});
		wr(IDX_DATA, 8'h11);
		repeat (40) @(posedge pclk);
		chk("no restart", {7'h00, pl}, {7'h00, sck_o});
		chk("peer rx", d, peer_u.rx);
		rdc("status", IDX_STAT, {1'b1, coll, 6'h00});
		rdc("data", IDX_DATA, pd);
		rdc("status clear", IDX_STAT, 8'h00);
		$display("test master finished");
	endtask
	task automatic t_slave();
		as_m <= 1'b1;
		clock_idle_level_bit_b <= 1'b0;
		clock_phase_bit_b <= 1'b0;
		wr(IDX_CTRL, 8'h43);
		wr(IDX_DATA, 8'hC3);
		peer_u.xfer(8'h5A, 8);
		chk("peer rx", 8'hC3, peer_u.rx);
		peer_u.xfer(8'h77, 8);
		chk("echo", 8'h5A, peer_u.rx);
		repeat (8) @(posedge pclk);
		rdc("status", IDX_STAT, 8'h80);
		rdc("data", IDX_DATA, 8'h5A);
		rdc("status clear", IDX_STAT, 8'h00);
		as_m <= 1'b0;
		$display("test slave finished");
	endtask
	task automatic t_fault();
		wr(IDX_CTRL, 8'hD1);
		ss_b <= 1'b0;
		repeat (10) @(posedge pclk);
		ss_b <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("fault irq", 8'h01, {7'h00, irq});
		wr(IDX_CTRL, 8'hD0);
		rdc("control", IDX_CTRL, 8'h80);
		rdc("status", IDX_STAT, 8'h10);
		wr(IDX_CTRL, 8'h50);
		rdc("control", IDX_CTRL, 8'h50);
		rdc("status", IDX_STAT, 8'h00);
		$display("test fault finished");
	endtask
	task automatic t_halt();
		wr(IDX_CTRL, 8'h0C);
		halt <= 1'b1;
		wr(IDX_CTRL, 8'h80);
		chk("halt irq", 8'h00, {7'h00, irq});
		halt <= 1'b0;
		rdc("control", IDX_CTRL, 8'h0C);
		$display("test halt finished");
	endtask
	// ==========================================================
	// Clock, sequence and watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h00000000;
		halt = 1'b0;
		ss_b = 1'b1;
		clock_idle_level_bit_b = 1'b0;
		clock_phase_bit_b = 1'b0;
		as_m = 1'b0;
		fails = 0;
		total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rates();
		t_master(1'b0, 1'b0, 1'b1, 8'hA5, 8'h3C);
		t_master(1'b1, 1'b1, 1'b0, 8'h96, 8'hC3);
		t_slave();
		t_fault();
		t_halt();
		final_report();
	end
	initial begin
		repeat (50000) @(posedge pclk);
		fails++;
		final_report();
	end
endmodule
`default_nettype wire
